/* File: rtl/lir_pkg.sv */
package lir_pkg;

  // Register bus
  localparam int unsigned WB_AW        = 8;
  localparam logic [7:0]  REG_TIMER    = 8'h00;
  localparam logic [7:0]  REG_PERF     = 8'h04;
  localparam logic [7:0]  REG_CORR     = 8'h08;
  localparam logic [7:0]  REG_PIN0     = 8'h0C;
  localparam logic [7:0]  REG_PIN1     = 8'h10;
  localparam logic [7:0]  REG_BASE_LO  = 8'h14;
  localparam logic [7:0]  REG_BASE_HI  = 8'h18;
  localparam logic [7:0]  REG_LOCAL_ID = 8'h1C;
  localparam logic [7:0]  REG_STATUS   = 8'h20;

  // Source configuration fields
  localparam int unsigned VEC_LSB      = 0;
  localparam int unsigned DT_LSB       = 8;
  localparam int unsigned POL_BIT      = 13;
  localparam int unsigned TRIG_BIT     = 15;
  localparam int unsigned DISCARD_BIT  = 16;
  localparam logic [31:0] CFG_RST      = 32'h0001_0000;
  localparam logic [31:0] SRC_WMASK    = 32'h0001_00FF;
  localparam logic [31:0] PIN_WMASK    = 32'h0001_A7FF;
  localparam logic [31:0] BASE_LO_WMASK = 32'hFFE0_0000;
  localparam logic [31:0] LID_WMASK    = 32'hFFFF_0000;
  localparam int unsigned LID_TGT_LSB  = 16;

  // Delivery types
  localparam logic [2:0]  DT_INT       = 3'h0;
  localparam logic [2:0]  DT_PLAT      = 3'h2;
  localparam logic [2:0]  DT_NMI       = 3'h4;
  localparam logic [2:0]  DT_INIT      = 3'h5;
  localparam logic [2:0]  DT_LEGACY    = 3'h7;

  // Vectors
  localparam logic [7:0]  VEC_ZERO     = 8'h00;
  localparam logic [7:0]  VEC_NMI      = 8'h02;
  localparam logic [7:0]  VEC_EXT_MIN  = 8'h10;
  localparam logic [7:0]  VEC_PLAT_MAX = 8'h03;

  // Interrupt block window
  localparam logic [63:0] BLK_BASE_RST = 64'h0000_0000_FEE0_0000;
  localparam int unsigned BLK_BITS     = 21;
  localparam int unsigned HALF_BIT     = 20;
  localparam logic [20:0] ACK_OFF      = 21'h1E_0000;
  localparam logic [20:0] HINT_OFF     = 21'h1E_0008;
  localparam int unsigned TGT_LSB      = 4;
  localparam int unsigned LB_BIT       = 3;
  localparam logic [3:0]  SIZE_BYTE    = 4'h1;
  localparam logic [3:0]  SIZE_DWORD   = 4'h8;

  // Sources
  localparam int unsigned NPIN         = 2;
  localparam int unsigned NSRC         = 6;
  localparam int unsigned SRC_TIMER    = 2;
  localparam int unsigned SRC_PERF     = 3;
  localparam int unsigned SRC_CORR     = 4;
  localparam int unsigned SRC_RX       = 5;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [63:0] addr;
    logic [3:0]  size;
    logic [63:0] data;
  } acc_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] target;
    logic        lb;
    logic [7:0]  vector;
    logic [2:0]  dtype;
  } msg_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  vector;
    logic [2:0]  dtype;
  } pend_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } hint_t;

endpackage

/* File: rtl/local_interrupt_routing.sv */
// Behaviour
// [R1] Timer vector low byte; valid 0,2,16-255
// [R2] Timer discard bit drops occurrences
// [R3] Perf overflow vector and discard bit
// [R4] Corrected error vector and discard bit
// [R5] Two pins, each with routing register
// [R6] Pin vector used only for plain delivery
// [R7] Delivery 000 vector, 010 platform-management zero
// [R8] Delivery 100 NMI, 101 init, 111 legacy
// [R9] Polarity bit selects active-low pin
// [R10] Edge mode: assertion edge pends interrupt
// [R11] Level mode: deassertion withdraws pending interrupt
// [R12] Software avoids level with platform-management or init
// [R13] Pin discard bit drops events
// [R14] Relocatable aligned 2 MByte block, reset base
// [R15] Aligned 8-byte low-half store sends message
// [R16] Only aligned 8-byte uncached stores below
// [R17] Upper half: single-byte uncached data only
// [R18] Byte at ack and hint offsets start cycles
// [R19] Misaligned message store raises fault
// [R20] Address bits 19:4 name target
// [R21] Address bit 3 forwarded as load balance
// [R22] Software gives valid target, lb support
// [R23] Message vector and delivery type fields
// [R24] Message 100/101/111 ignore vector
// [R25] Incoming message matching own name pends
// [R26] Message data bits above 10 ignored
// [R27] Surviving event presented within one cycle; O_PEND.valid here rises two cycles after the event
// [R28] Pins pass two-stage synchroniser first
//
// Decided for this implementation: the register offsets and the Wishbone slave port.
module local_interrupt_routing
  import lir_pkg::*;
#(
  parameter logic [63:0] BLK_BASE = BLK_BASE_RST
) (
  // Clock and reset
  input  wire logic             I_CORE_CLK,
  input  wire logic             I_RST_N,
  // Wishbone slave
  input  wire logic             I_WB_CYC,
  input  wire logic             I_WB_STB,
  input  wire logic             I_WB_WE,
  input  wire logic [WB_AW-1:0] I_WB_ADR,
  input  wire logic [3:0]       I_WB_SEL,
  input  wire logic [31:0]      I_WB_DAT,
  output logic      [31:0]      O_WB_DAT,
  output logic                  O_WB_ACK,
  // Local sources
  input  wire logic             I_TIMER_EVT,
  input  wire logic             I_PERF_OVF_EVT,
  input  wire logic             I_CORR_ERR_EVT,
  input  wire logic             I_LOCAL_PIN_ZERO,
  input  wire logic             I_LOCAL_PIN_ONE,
  // Core accesses to the interrupt block
  input  wire acc_t             I_ACC,
  output logic                  O_FAULT,
  // System bus side
  output msg_t                  O_MSG,
  output logic                  O_ACK_CYC,
  output hint_t                 O_HINT,
  input  wire msg_t             I_RX,
  // Pending-interrupt logic
  output pend_t                 O_PEND,
  output pend_t                 O_WITHDRAW
);

  if (BLK_BASE[BLK_BITS-1:0] != '0) begin : g_base_chk
    $error("block base must be aligned to the block size");
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic vec_ok(input logic [7:0] v);
    return (v == VEC_ZERO) || (v == VEC_NMI) || (v >= VEC_EXT_MIN);
  endfunction

  // Pins route by delivery type; other local sources always deliver plainly
  function automatic pend_t resolve(input logic [7:0] v, input logic [2:0] dt,
                                    input logic level, input logic is_msg);
    pend_t r;
    r.valid  = 1'b1;
    r.vector = VEC_ZERO;
    r.dtype  = dt;
    case (dt)
      DT_INT: begin
        r.vector = v;
        r.valid  = vec_ok(v);
      end
      DT_PLAT: begin
        r.vector = is_msg ? v : VEC_ZERO;
        r.valid  = !level && (!is_msg || v <= VEC_PLAT_MAX);
      end
      DT_NMI:    r.vector = VEC_NMI;
      DT_INIT:   r.valid  = !level;
      DT_LEGACY: r.vector = VEC_ZERO;
      default:   r.valid  = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] wr(input logic [31:0] old, input logic [31:0] nw,
                                     input logic [3:0] sel, input logic [31:0] m);
    logic [31:0] be;
    be = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & m;
    return (old & ~be) | (nw & be);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0]      cfg_q [NSRC-1];
  logic [63:0]      base_q;
  logic [31:0]      lid_q;
  logic [NSRC-1:0]  slot_q;
  logic [7:0]       slot_vec_q [NSRC];
  logic [2:0]       slot_dt_q [NSRC];
  logic [NPIN-1:0]  pin_act;
  logic             wb_req;
  logic             wb_wr;

  assign wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
  assign wb_wr  = wb_req && I_WB_WE;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_WB_ACK <= 1'b0;
    end else begin
      O_WB_ACK <= wb_req;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      for (int i = 0; i < NSRC - 1; i++) begin
        cfg_q[i] <= CFG_RST;
      end
      base_q <= BLK_BASE;                                          // R14
      lid_q  <= '0;
    end else if (wb_wr) begin
      case (I_WB_ADR)
        REG_TIMER:    cfg_q[SRC_TIMER] <= wr(cfg_q[SRC_TIMER], I_WB_DAT, I_WB_SEL, SRC_WMASK);
        REG_PERF:     cfg_q[SRC_PERF] <= wr(cfg_q[SRC_PERF], I_WB_DAT, I_WB_SEL, SRC_WMASK);
        REG_CORR:     cfg_q[SRC_CORR] <= wr(cfg_q[SRC_CORR], I_WB_DAT, I_WB_SEL, SRC_WMASK);
        REG_PIN0:     cfg_q[0] <= wr(cfg_q[0], I_WB_DAT, I_WB_SEL, PIN_WMASK);
        REG_PIN1:     cfg_q[1] <= wr(cfg_q[1], I_WB_DAT, I_WB_SEL, PIN_WMASK);
        // Low 21 base bits are not writable, so the block stays aligned
        REG_BASE_LO:  base_q[31:0] <= wr(base_q[31:0], I_WB_DAT, I_WB_SEL, BASE_LO_WMASK); // R14
        REG_BASE_HI:  base_q[63:32] <= wr(base_q[63:32], I_WB_DAT, I_WB_SEL, '1);
        REG_LOCAL_ID: lid_q <= wr(lid_q, I_WB_DAT, I_WB_SEL, LID_WMASK);
        default: ;
      endcase
    end
  end

  // Unmapped addresses are acknowledged and read as zero
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_WB_DAT <= '0;
    end else if (wb_req && !I_WB_WE) begin
      case (I_WB_ADR)
        REG_TIMER:    O_WB_DAT <= cfg_q[SRC_TIMER];
        REG_PERF:     O_WB_DAT <= cfg_q[SRC_PERF];
        REG_CORR:     O_WB_DAT <= cfg_q[SRC_CORR];
        REG_PIN0:     O_WB_DAT <= cfg_q[0];
        REG_PIN1:     O_WB_DAT <= cfg_q[1];
        REG_BASE_LO:  O_WB_DAT <= base_q[31:0];
        REG_BASE_HI:  O_WB_DAT <= base_q[63:32];
        REG_LOCAL_ID: O_WB_DAT <= lid_q;
        REG_STATUS:   O_WB_DAT <= {24'h00_0000, slot_q, pin_act};
        default:      O_WB_DAT <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins
  logic [NPIN-1:0]  pin_raw;
  logic [1:0]       sync_q [NPIN];
  logic [NPIN-1:0]  act_q;
  logic [NPIN-1:0]  pin_rise;
  logic [NPIN-1:0]  pin_fall;
  logic [NPIN-1:0]  lvl_q;
  logic [7:0]       lvl_vec_q [NPIN];
  logic [2:0]       lvl_dt_q [NPIN];
  logic [NPIN-1:0]  wd_q;

  assign pin_raw = {I_LOCAL_PIN_ONE, I_LOCAL_PIN_ZERO};            // R5

  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
        sync_q[p] <= 2'h0;
        act_q[p]  <= 1'b0;
      end else begin
        sync_q[p] <= {sync_q[p][0], pin_raw[p]};                   // R28
        act_q[p]  <= pin_act[p];
      end
    end
    assign pin_act[p]  = sync_q[p][1] ^ cfg_q[p][POL_BIT];         // R9
    assign pin_rise[p] = pin_act[p] && !act_q[p];
    assign pin_fall[p] = !pin_act[p] && act_q[p];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event resolution
  logic [NSRC-1:0]  evt;
  pend_t            res [NSRC];
  logic [NSRC-1:0]  set;
  logic [NPIN-1:0]  wd_set;
  logic [NSRC-1:0]  cancel;
  logic             rx_match;

  assign evt = {I_RX.valid, I_CORR_ERR_EVT, I_PERF_OVF_EVT, I_TIMER_EVT, pin_rise};
  // Only the name fields are compared; data bits above the type are dropped
  assign rx_match = I_RX.target == lid_q[LID_TGT_LSB +: 16];       // R25

  always_comb begin
    for (int s = 0; s < NPIN; s++) begin
      res[s] = resolve(cfg_q[s][VEC_LSB +: 8], cfg_q[s][DT_LSB +: 3],
                       cfg_q[s][TRIG_BIT], 1'b0);                  // R6 R7 R8
      set[s] = evt[s] && res[s].valid && !cfg_q[s][DISCARD_BIT];   // R10 R13
      wd_set[s] = pin_fall[s] && cfg_q[s][TRIG_BIT] && lvl_q[s] && !slot_q[s]; // R11
      cancel[s] = pin_fall[s] && cfg_q[s][TRIG_BIT];               // R11
    end
    for (int s = SRC_TIMER; s <= SRC_CORR; s++) begin
      res[s] = resolve(cfg_q[s][VEC_LSB +: 8], DT_INT, 1'b0, 1'b0); // R1 R3 R4
      set[s] = evt[s] && res[s].valid && !cfg_q[s][DISCARD_BIT];   // R2 R3 R4
      cancel[s] = 1'b0;
    end
    res[SRC_RX] = resolve(I_RX.vector, I_RX.dtype, 1'b0, 1'b1);     // R24 R26
    set[SRC_RX] = evt[SRC_RX] && rx_match && res[SRC_RX].valid;     // R25
    cancel[SRC_RX] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending slots: lowest index first, a new event beats the grant clear
  logic [NSRC-1:0]  grant;
  logic [NPIN-1:0]  wd_grant;

  always_comb begin
    grant = '0;
    for (int s = NSRC - 1; s >= 0; s--) begin
      if (slot_q[s]) begin
        grant = '0;
        grant[s] = 1'b1;
      end
    end
    wd_grant = '0;
    for (int s = NPIN - 1; s >= 0; s--) begin
      if (wd_q[s]) begin
        wd_grant = '0;
        wd_grant[s] = 1'b1;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      slot_q <= '0;
      for (int s = 0; s < NSRC; s++) begin
        slot_vec_q[s] <= VEC_ZERO;
        slot_dt_q[s]  <= DT_INT;
      end
    end else begin
      for (int s = 0; s < NSRC; s++) begin
        if (set[s]) begin
          slot_q[s]     <= 1'b1;
          slot_vec_q[s] <= res[s].vector;
          slot_dt_q[s]  <= res[s].dtype;
        end else if (grant[s] || cancel[s]) begin
          slot_q[s] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_PEND <= '0;
    end else begin
      O_PEND.valid <= |slot_q;                                     // R27
      O_PEND.vector <= VEC_ZERO;
      O_PEND.dtype <= DT_INT;
      for (int s = 0; s < NSRC; s++) begin
        if (grant[s]) begin
          O_PEND.vector <= slot_vec_q[s];
          O_PEND.dtype  <= slot_dt_q[s];
        end
      end
    end
  end

  // Level records let a deassertion withdraw what was already handed out
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      lvl_q <= '0;
      wd_q  <= '0;
      for (int s = 0; s < NPIN; s++) begin
        lvl_vec_q[s] <= VEC_ZERO;
        lvl_dt_q[s]  <= DT_INT;
      end
    end else begin
      for (int s = 0; s < NPIN; s++) begin
        if (set[s] && cfg_q[s][TRIG_BIT]) begin
          lvl_q[s]     <= 1'b1;
          lvl_vec_q[s] <= res[s].vector;
          lvl_dt_q[s]  <= res[s].dtype;
        end else if (pin_fall[s]) begin
          lvl_q[s] <= 1'b0;
        end
        if (wd_set[s]) begin
          wd_q[s] <= 1'b1;
        end else if (wd_grant[s]) begin
          wd_q[s] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_WITHDRAW <= '0;
    end else begin
      O_WITHDRAW.valid <= |wd_q;                                   // R11
      O_WITHDRAW.vector <= VEC_ZERO;
      O_WITHDRAW.dtype <= DT_INT;
      for (int s = 0; s < NPIN; s++) begin
        if (wd_grant[s]) begin
          O_WITHDRAW.vector <= lvl_vec_q[s];
          O_WITHDRAW.dtype  <= lvl_dt_q[s];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt block decode
  logic        in_blk;
  logic [20:0] blk_off;
  logic        lo_half;
  logic        msg_ok;
  logic        msg_bad;
  logic        ack_hit;
  logic        hint_hit;

  assign in_blk   = I_ACC.valid && I_ACC.addr[63:BLK_BITS] == base_q[63:BLK_BITS]; // R14
  assign blk_off  = I_ACC.addr[BLK_BITS-1:0];
  assign lo_half  = !blk_off[HALF_BIT];
  assign msg_ok   = in_blk && lo_half && I_ACC.we && I_ACC.size == SIZE_DWORD
                    && I_ACC.addr[2:0] == 3'h0;                    // R15
  assign msg_bad  = in_blk && lo_half && I_ACC.we && !msg_ok;      // R19
  assign ack_hit  = in_blk && !lo_half && I_ACC.size == SIZE_BYTE && blk_off == ACK_OFF;
  assign hint_hit = in_blk && !lo_half && I_ACC.size == SIZE_BYTE && I_ACC.we
                    && blk_off == HINT_OFF;

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_MSG <= '0;
    end else begin
      O_MSG.valid  <= msg_ok;                                      // R15
      O_MSG.target <= I_ACC.addr[TGT_LSB +: 16];                   // R20
      O_MSG.lb     <= I_ACC.addr[LB_BIT];                          // R21
      O_MSG.vector <= I_ACC.data[VEC_LSB +: 8];                    // R23
      O_MSG.dtype  <= I_ACC.data[DT_LSB +: 3];                     // R23 R26
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_FAULT   <= 1'b0;
      O_ACK_CYC <= 1'b0;
      O_HINT    <= '0;
    end else begin
      O_FAULT     <= msg_bad;                                      // R19
      O_ACK_CYC   <= ack_hit;                                      // R18
      O_HINT.valid <= hint_hit;                                    // R18
      O_HINT.data  <= I_ACC.data[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);

  sequence s_msg_store;
    msg_ok;
  endsequence

  sequence s_msg_out;
    O_MSG.valid && !O_FAULT;
  endsequence

  property p_msg_sent;
    s_msg_store |=> s_msg_out;
  endproperty
  a_msg_sent: assert property (p_msg_sent) else $error("message not sent"); // R15

  property p_msg_target;
    O_MSG.valid |-> O_MSG.target == $past(I_ACC.addr[TGT_LSB +: 16])
                    && O_MSG.lb == $past(I_ACC.addr[LB_BIT]);
  endproperty
  a_msg_target: assert property (p_msg_target) else $error("bad target"); // R20 R21

  property p_misaligned;
    (in_blk && lo_half && I_ACC.we && I_ACC.addr[2:0] != 3'h0) |=> O_FAULT && !O_MSG.valid;
  endproperty
  a_misaligned: assert property (p_misaligned) else $error("misaligned accepted"); // R19

  property p_ack_cycle;
    (I_ACC.valid && I_ACC.addr == base_q + 64'(ACK_OFF)
     && I_ACC.size == SIZE_BYTE) |=> O_ACK_CYC;
  endproperty
  a_ack_cycle: assert property (p_ack_cycle) else $error("no ack cycle"); // R18

  property p_hint_data;
    O_HINT.valid |-> O_HINT.data == $past(I_ACC.data[7:0]) && $past(hint_hit);
  endproperty
  a_hint_data: assert property (p_hint_data) else $error("bad hint"); // R18

  property p_timer_discard;
    (I_TIMER_EVT && cfg_q[SRC_TIMER][DISCARD_BIT] && !slot_q[SRC_TIMER])
      |=> !slot_q[SRC_TIMER];
  endproperty
  a_timer_discard: assert property (p_timer_discard) else $error("discarded pended"); // R2

  property p_present;
    // A pin set in the same cycle would win the grant, so it is excluded
    (set[SRC_TIMER] && set[NPIN-1:0] == '0 && slot_q == '0) |=> ##1 O_PEND.valid
      && O_PEND.vector == $past(cfg_q[SRC_TIMER][VEC_LSB +: 8], 2);
  endproperty
  a_present: assert property (p_present) else $error("late pend"); // R27

  property p_sync;
    sync_q[0][1] == $past(I_LOCAL_PIN_ZERO, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("pin not synchronised"); // R28

  property p_rx_foreign;
    (I_RX.valid && !rx_match && !slot_q[SRC_RX]) |=> !slot_q[SRC_RX];
  endproperty
  a_rx_foreign: assert property (p_rx_foreign) else $error("foreign message taken"); // R25

  property p_wb_ack;
    O_WB_ACK |=> !O_WB_ACK;
  endproperty
  a_wb_ack: assert property (p_wb_ack) else $error("ack held");

endmodule

/* File: verification/ipi_fabric_model.sv */
module msg_fabric_model
  import lir_pkg::*;
#(
  parameter int unsigned DELAY = 3
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Outgoing from the block, incoming back to it
  input  wire msg_t i_msg,
  output msg_t      o_rx
);
  timeunit 1ns;
  timeprecision 1ps;

  msg_t        held_q;
  int unsigned wait_q;
  logic        busy_q;

  // Shared bus: every processor sees each message and matches the name itself,
  // so the named processor always gets it; redirection is never exercised
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      held_q <= '0;
      wait_q <= 0;
      busy_q <= 1'b0;
      o_rx   <= '0;
    end else begin
      if (i_msg.valid) begin
        held_q <= i_msg;
        busy_q <= 1'b1;
        wait_q <= DELAY;
      end else if (busy_q && wait_q != 0) begin
        wait_q <= wait_q - 1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
      end
      // Idle fields toggle so a stale value is never taken for data
      if (busy_q && wait_q == 0) o_rx <= held_q;
      else o_rx <= {1'b0, ~o_rx[27:0]};
    end
  end
endmodule

/* File: verification/local_interrupt_routing_bench.sv */
module local_interrupt_routing_bench
  import lir_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {int src; logic [7:0] adr; logic [31:0] cfg; logic ev; logic [10:0] vd;} row_t;

  logic             clk   = 1'b0;
  logic             rst_n = 1'b0;
  logic             cyc   = 1'b0;
  logic             stb   = 1'b0;
  logic             we    = 1'b0;
  logic [WB_AW-1:0] adr   = '0;
  logic [3:0]       sel   = '0;
  logic [31:0]      wdat  = '0;
  logic [2:0]       evt   = '0;
  logic [1:0]       pin   = '0;
  acc_t             acc   = '0;
  logic [31:0]      rdat;
  logic             ack;
  logic             fault;
  logic             ack_cyc;
  msg_t             msg;
  msg_t             rx;
  hint_t            hint;
  pend_t            pend;
  pend_t            wd;
  pend_t            last_pend;
  pend_t            last_wd;
  logic [3:0]       obs;
  int               errors   = 0;
  int               n_checks = 0;
  int               n_pend   = 0;
  int               n_wd     = 0;

  row_t rows[15] = '{
    '{0, REG_TIMER, 32'h0000_0020, 1, 11'h100}, '{0, REG_TIMER, 32'h0000_0005, 0, 0},
    '{0, REG_TIMER, 32'h0001_0020, 0, 0}, '{1, REG_PERF, 32'h0000_0002, 1, 11'h010},
    '{1, REG_PERF, 32'h0001_00FF, 0, 0}, '{2, REG_CORR, 32'h0000_0000, 1, 11'h000},
    '{2, REG_CORR, 32'h0000_000F, 0, 0}, '{2, REG_CORR, 32'h0000_0010, 1, 11'h080},
    '{3, REG_PIN0, 32'h0000_0030, 1, 11'h180}, '{3, REG_PIN0, 32'h0000_0108, 0, 0},
    '{3, REG_PIN0, 32'h0000_0255, 1, 11'h002}, '{3, REG_PIN0, 32'h0000_0455, 1, 11'h014},
    '{3, REG_PIN0, 32'h0000_0555, 1, 11'h005}, '{3, REG_PIN0, 32'h0000_0755, 1, 11'h007},
    '{4, REG_PIN1, 32'h0000_0031, 1, 11'h188}};

  local_interrupt_routing #(.BLK_BASE(BLK_BASE_RST)) local_interrupt_routing_i (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
    .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
    .I_TIMER_EVT(evt[0]), .I_PERF_OVF_EVT(evt[1]), .I_CORR_ERR_EVT(evt[2]),
    .I_LOCAL_PIN_ZERO(pin[0]), .I_LOCAL_PIN_ONE(pin[1]), .I_ACC(acc), .O_FAULT(fault),
    .O_MSG(msg), .O_ACK_CYC(ack_cyc), .O_HINT(hint), .I_RX(rx), .O_PEND(pend),
    .O_WITHDRAW(wd));

  msg_fabric_model #(.DELAY(3)) msg_fabric_model_i (
    .i_clk(clk), .i_rst_n(rst_n), .i_msg(msg), .o_rx(rx));

  initial begin
    forever #10 clk = ~clk;
  end

  // Pulses stand one cycle, so count them at every edge
  always @(posedge clk) begin
    if (pend.valid === 1'b1) begin
      n_pend++;
      last_pend = pend;
    end
    if (wd.valid === 1'b1) begin
      n_wd++;
      last_wd = wd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdat} <= {1'b1, 1'b1, w, a, 4'hF, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n == 20) chk("wb_ack", 1, ack);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(what, exp, q);
  endtask

  task automatic core(input logic w, input logic [63:0] a, input logic [3:0] sz,
                      input logic [63:0] d);
    @(posedge clk);
    acc <= '{valid: 1'b1, we: w, addr: a, size: sz, data: d};
    @(posedge clk);
    acc.valid <= 1'b0;
    #1;
    obs = {fault, ack_cyc, hint.valid, msg.valid};
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    settle(8);
    rst_n <= 1'b1;
    rd_chk("timer_rst", REG_TIMER, CFG_RST);
    rd_chk("pin0_rst", REG_PIN0, CFG_RST);
    rd_chk("base_lo_rst", REG_BASE_LO, BLK_BASE_RST[31:0]);
    rd_chk("base_hi_rst", REG_BASE_HI, BLK_BASE_RST[63:32]);
    rd_chk("unmapped", 8'h24, 32'h0);
    wr(REG_TIMER, 32'hFFFF_FFFF);
    rd_chk("timer_bits", REG_TIMER, SRC_WMASK);
    wr(REG_PIN1, 32'hFFFF_FFFF);
    rd_chk("pin1_bits", REG_PIN1, PIN_WMASK);
    $display("test registers done");
    foreach (rows[i]) begin
      wr(rows[i].adr, rows[i].cfg);
      settle(6);
      {n_pend, n_wd} = 0;
      @(posedge clk);
      if (rows[i].src < 3) evt[rows[i].src] <= 1'b1;
      else pin[rows[i].src-3] <= 1'b1;
      @(posedge clk);
      evt <= '0;
      settle(8);
      if (rows[i].src >= 3) pin <= '0;
      settle(8);
      chk("pend_cnt", rows[i].ev, n_pend);
      if (rows[i].ev) chk("pend_vd", rows[i].vd, {last_pend.vector, last_pend.dtype});
      chk("edge_wd_cnt", 0, n_wd);
    end
    $display("test sources done");
    wr(REG_PIN1, 32'h0001_2040);
    pin[1] <= 1'b1;
    settle(8);
    n_pend = 0;
    wr(REG_PIN1, 32'h0000_2040);
    settle(8);
    chk("pol_idle", 0, n_pend);
    pin[1] <= 1'b0;
    settle(8);
    chk("pol_vd", 11'h140, {n_pend[2:0], last_pend.vector});
    rd_chk("status", REG_STATUS, 32'h0000_0002);
    wr(REG_PIN0, 32'h0000_8050);
    {n_pend, n_wd} = 0;
    pin[0] <= 1'b1;
    settle(10);
    chk("lvl_pend", 11'h150, {n_pend[2:0], last_pend.vector});
    pin[0] <= 1'b0;
    settle(10);
    chk("lvl_wd", 11'h150, {n_wd[2:0], last_wd.vector});
    $display("test pins done");
    wr(REG_LOCAL_ID, 32'h1234_0000);
    n_pend = 0;
    core(1'b1, BLK_BASE_RST | 64'h0001_2348, SIZE_DWORD, 64'hDEAD_BEEF_FFFF_F861);
    chk("cross_msg", {3'h0, 29'({1'b1, 16'h1234, 1'b1, 8'h61, 3'h0})}, 32'(msg));
    settle(10);
    chk("rx_pend", 12'hB08, {n_pend[0], last_pend.vector, last_pend.dtype});
    n_pend = 0;
    core(1'b1, BLK_BASE_RST | 64'h0000_0420, SIZE_DWORD, 64'h0000_0000_0000_0203);
    chk("plat_msg", {3'h0, 29'({1'b1, 16'h0042, 1'b0, 8'h03, 3'h2})}, 32'(msg));
    settle(10);
    chk("foreign", 0, n_pend);
    for (int t = 0; t < 3; t++) begin
      n_pend = 0;
      core(1'b1, BLK_BASE_RST | 64'h0001_2340, SIZE_DWORD, 64'h0455 + (64'(t + (t == 2)) << 8));
      settle(10);
      chk("rx_type", {1'b1, t == 0 ? 8'h02 : 8'h00, 3'h4 + 3'(t) + 3'(t == 2)},
          {n_pend[0], last_pend.vector, last_pend.dtype});
    end
    core(1'b1, BLK_BASE_RST | 64'h0000_0014, SIZE_DWORD, 64'h30);
    chk("unaligned", 4'b1000, obs);
    core(1'b0, BLK_BASE_RST | 64'h0000_0010, SIZE_DWORD, 64'h0);
    chk("low_load", 4'b0000, obs);
    core(1'b0, BLK_BASE_RST + 64'(ACK_OFF), SIZE_BYTE, 64'h0);
    chk("ack_cycle", 4'b0100, obs);
    core(1'b1, BLK_BASE_RST + 64'(HINT_OFF), SIZE_BYTE, 64'hA5);
    chk("hint_cycle", 12'h2A5, {obs, hint.data});
    wr(REG_BASE_LO, 32'h0040_0000);
    core(1'b1, 64'h0040_0420, SIZE_DWORD, 64'h0020);
    chk("moved_hit", 4'b0001, obs);
    core(1'b1, BLK_BASE_RST | 64'h0000_0420, SIZE_DWORD, 64'h0020);
    chk("moved_old", 4'b0000, obs);
    $display("test block done");
    rst_n <= 1'b0;
    settle(3);
    rst_n <= 1'b1;
    rd_chk("timer_rerst", REG_TIMER, CFG_RST);
    rd_chk("base_rerst", REG_BASE_LO, BLK_BASE_RST[31:0]);
    $display("test reset done");
    test_done();
  end

  // The run needs under 3000 cycles; this limit leaves ample margin
  initial begin
    #(40000 * 20);
    chk("watchdog", 0, 1);
    test_done();
  end
endmodule
